/* File: rtl/csst_pkg.sv */
package csst_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // main control register fields
  localparam logic [7:0] MC_RESET     = 8'h00;
  localparam int unsigned MC_POWER_BIT = 7;
  localparam int unsigned MC_TXE_BIT   = 6;
  localparam int unsigned MC_RXE_BIT   = 5;
  localparam int unsigned MC_DIR_BIT   = 4;
  localparam int unsigned MC_CONT_BIT  = 1;
  localparam int unsigned MC_SCE_BIT   = 0;

  ////////////////////////////////////////////////////////////////////////////
  // clock / phase control register fields
  localparam logic [7:0] CP_RESET     = 8'h00;
  localparam int unsigned CP_CKP_BIT   = 4;
  localparam int unsigned CP_DAP_BIT   = 3;
  localparam int unsigned CP_CKS_LSB   = 0;
  localparam int unsigned CP_CKS_W     = 3;
  localparam logic [2:0] CKS_DIV2     = 3'h0;
  localparam logic [2:0] CKS_SLAVE    = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // length control register fields
  localparam logic [7:0] LEN_RESET    = 8'h00;
  localparam int unsigned LEN_TOP_BIT  = 3;
  localparam logic [4:0] LEN_BASE     = 5'h08;
  localparam logic [4:0] LEN_MAX      = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // status register fields
  localparam int unsigned ST_TSF_BIT   = 7;
  localparam int unsigned ST_OVE_BIT   = 0;

  ////////////////////////////////////////////////////////////////////////////
  // sizes and serial clock reset level
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam int unsigned DIV_W        = 6;
  localparam logic        SCK_RESET    = 1'h1;

  typedef enum logic [1:0] {
    CSST_IDLE = 2'b01,
    CSST_RUN  = 2'b10
  } csst_state_t;

endpackage

/* File: rtl/csst_sync.sv */
`timescale 1ns/1ns
module csst_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } csst_sync_t;

  csst_sync_t r_q;
  csst_sync_t r_d;

  // first stage feeds only the second stage
  always_comb
  begin
    r_d    = r_q;
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  assign q = r_q.s2;

endmodule

/* File: rtl/csst_fifo.sv */
`timescale 1ns/1ns
module csst_fifo #(
  parameter int unsigned W     = 16,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         clr,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic      [W-1:0] out_data,
  input  wire logic         out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0]   DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C  = AW'(DEPTH - 1);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          full;
    logic          empty;
  } csst_fifo_t;

  csst_fifo_t    q;
  csst_fifo_t    d;
  logic [W-1:0]  mem [DEPTH];
  logic          push;
  logic          pop;

  assign push = in_valid & ~q.full;
  assign pop  = out_ready & ~q.empty;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    d = q;
    if (push)
      d.wp = (q.wp == LAST_C) ? '0 : q.wp + 1'b1;
    if (pop)
      d.rp = (q.rp == LAST_C) ? '0 : q.rp + 1'b1;
    if (push & ~pop)
      d.cnt = q.cnt + 1'b1;
    else if (pop & ~push)
      d.cnt = q.cnt - 1'b1;
    if (clr)
    begin
      d.wp  = '0;
      d.rp  = '0;
      d.cnt = '0;
    end
    // flags registered so in_ready and out_valid come from flip-flops
    d.full  = (d.cnt == DEPTH_C);
    d.empty = (d.cnt == '0);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      q       <= '0;
      q.empty <= 1'b1;
    end
    else
      q <= d;
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[q.wp] <= in_data;
  end

  assign in_ready  = ~q.full;
  assign out_valid = ~q.empty;
  assign out_data  = mem[q.rp];

endmodule

/* File: rtl/csst_channel.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - control 00H: type 1, clock/2, master
// - control 07H: type 1, external clock, slave
// - source code 000 div2, 111 external
// - direction 0 msb first; 00 type 1
// - length 00H gives eight-bit frames
// - C1H: powered, transmit only, msb first
// - A1H: powered, receive only, msb first
// - E1H: powered, transmit and receive together
// - master transmit write sets busy, starts
// - receive only: dummy read starts reception
// - master drives clock, shifts data out
// - data in sampled with serial clock
// - after length: stop, clear busy, interrupt
// - interrupt also ends transmit-only frames
// - slave write sets busy, waits clock
// - slave shifts on master clock edges
// - read with continue set restarts reception
// - continue cleared: read starts nothing
// - length 8 to 16, right aligned
// - overrun when unread data is overwritten
// - overrun cleared by zero; power clears status
module csst_channel (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        main_ctl_wr,
  input  wire logic [7:0]  main_ctl_wdata,
  input  wire logic        clk_phase_wr,
  input  wire logic [7:0]  clk_phase_wdata,
  input  wire logic        len_ctl_wr,
  input  wire logic [7:0]  len_ctl_wdata,
  input  wire logic        status_wr,
  input  wire logic [7:0]  status_wdata,
  input  wire logic        tx_wr,
  input  wire logic [15:0] tx_wdata,
  output logic             tx_ready,
  input  wire logic        rx_rd,
  output logic      [15:0] rx_data,
  output logic      [7:0]  main_control_reg,
  output logic      [7:0]  clock_phase_control_reg,
  output logic      [7:0]  length_control_reg,
  output logic      [7:0]  channel_status_reg,
  output logic             communicating_flag,
  output logic             overrun_flag,
  output logic             reception_complete_irq,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe,
  output logic             serial_data_out_pin,
  input  wire logic        serial_data_in_pin
);

  typedef struct packed {
    csst_pkg::csst_state_t             st;
    logic [7:0]                        mc;
    logic [7:0]                        cp;
    logic [7:0]                        len;
    logic [csst_pkg::DATA_W-1:0]       sh;
    logic [csst_pkg::DATA_W-1:0]       rx;
    logic [4:0]                        bitcnt;
    logic [csst_pkg::DIV_W-1:0]        div;
    logic                              sck;
    logic                              sck_oe;
    logic                              dout;
    logic                              sck_prev;
    logic                              comm;
    logic                              ovf;
    logic                              unread;
    logic                              irq;
  } csst_chan_t;

  localparam csst_chan_t CHAN_RESET = '{
    st:       csst_pkg::CSST_IDLE,
    mc:       csst_pkg::MC_RESET,
    cp:       csst_pkg::CP_RESET,
    len:      csst_pkg::LEN_RESET,
    sck:      csst_pkg::SCK_RESET,
    default:  '0
  };

  csst_chan_t                  q;
  csst_chan_t                  d;

  logic                        power;
  logic                        txe;
  logic                        rxe;
  logic                        lsb_first;
  logic                        sce;
  logic                        dap;
  logic                        idle_lvl;
  logic [2:0]                  cks;
  logic                        master;
  logic                        cfg_open;
  logic [4:0]                  nbits;
  logic [16:0]                 ones;
  logic [csst_pkg::DATA_W-1:0] mask;
  logic [6:0]                  half_full;
  logic [csst_pkg::DIV_W-1:0]  half_m1;
  logic                        run;
  logic                        tick;
  logic                        s_sck;
  logic                        lead;
  logic                        trail;
  logic                        last_bit;
  logic                        tx_push;
  logic                        fifo_in_ready;
  logic                        fifo_valid;
  logic [csst_pkg::DATA_W-1:0] fifo_data;
  logic                        fifo_pop;
  logic                        fifo_clr;
  logic                        sin;
  logic [csst_pkg::DATA_W-1:0] sh_next;

  ////////////////////////////////////////////////////////////////////////////
  // shift helpers

  function automatic logic out_bit(
    input logic [csst_pkg::DATA_W-1:0] sh,
    input logic                        lsbf,
    input logic [4:0]                  n
  );
    logic [4:0] top;
    top = n - 5'h01;
    out_bit = lsbf ? sh[0] : sh[top[3:0]];
  endfunction

  function automatic logic [csst_pkg::DATA_W-1:0] shift_in(
    input logic [csst_pkg::DATA_W-1:0] sh,
    input logic                        din,
    input logic                        lsbf,
    input logic [4:0]                  n
  );
    logic [4:0]                  top;
    logic [csst_pkg::DATA_W-1:0] r;
    top = n - 5'h01;
    if (lsbf)
    begin
      r           = sh >> 1;
      r[top[3:0]] = din;
    end
    else
      r = {sh[csst_pkg::DATA_W-2:0], din};
    shift_in = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode of the control registers

  assign power     = q.mc[csst_pkg::MC_POWER_BIT];
  assign txe       = q.mc[csst_pkg::MC_TXE_BIT];
  assign rxe       = q.mc[csst_pkg::MC_RXE_BIT];
  assign lsb_first = q.mc[csst_pkg::MC_DIR_BIT];
  assign sce       = q.mc[csst_pkg::MC_SCE_BIT];
  assign dap       = q.cp[csst_pkg::CP_DAP_BIT];
  // ckp 0 idles high, which is communication type 1
  assign idle_lvl  = ~q.cp[csst_pkg::CP_CKP_BIT];
  assign cks       = q.cp[csst_pkg::CP_CKS_LSB +: csst_pkg::CP_CKS_W];
  assign master    = (cks != csst_pkg::CKS_SLAVE);
  assign cfg_open  = ~power | ~(txe | rxe);

  // eight plus the low field, or sixteen when the top bit is set
  assign nbits = q.len[csst_pkg::LEN_TOP_BIT] ? csst_pkg::LEN_MAX :
                 csst_pkg::LEN_BASE + {2'h0, q.len[2:0]};
  assign ones  = (17'h00001 << nbits) - 17'h00001;
  assign mask  = ones[csst_pkg::DATA_W-1:0];

  // half period of 2^cks clocks; code 000 gives clock/2
  assign half_full = (7'h01 << cks) - 7'h01;
  assign half_m1   = half_full[csst_pkg::DIV_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // serial clock edges

  csst_sync #(
    .W (1)
  ) u_sck_sync (
    .mclk (mclk),
    .srst (srst),
    .d    (serial_clock_pin_i),
    .q    (s_sck)
  );

  assign run  = (q.st == csst_pkg::CSST_RUN);
  assign tick = run & master & (q.div == half_m1);

  // slave edges come late by the synchroniser; the peer clock must stay
  // well below a quarter of mclk
  always_comb
  begin
    if (master)
    begin
      lead  = tick & (q.sck == idle_lvl);
      trail = tick & (q.sck != idle_lvl);
    end
    else
    begin
      lead  = run & (s_sck != q.sck_prev) & (q.sck_prev == idle_lvl);
      trail = run & (s_sck != q.sck_prev) & (q.sck_prev != idle_lvl);
    end
  end

  assign last_bit = (q.bitcnt == nbits - 5'h01);
  assign sin      = rxe & serial_data_in_pin;
  assign sh_next  = shift_in(q.sh, sin, lsb_first, nbits);

  ////////////////////////////////////////////////////////////////////////////
  // transmit buffer

  assign tx_push  = tx_wr & power & txe & fifo_in_ready;
  assign fifo_clr = ~power;

  csst_fifo #(
    .W     (csst_pkg::DATA_W),
    .DEPTH (csst_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk      (mclk),
    .srst      (srst),
    .clr       (fifo_clr),
    .in_valid  (tx_push),
    .in_data   (tx_wdata),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    d          = q;
    d.irq      = 1'b0;
    d.sck_prev = s_sck;
    fifo_pop   = 1'b0;

    if (main_ctl_wr)
      d.mc = main_ctl_wdata;
    // clock and length settings frozen while powered with either enable set
    if (clk_phase_wr & cfg_open)
      d.cp = clk_phase_wdata;
    if (len_ctl_wr & cfg_open)
      d.len = len_ctl_wdata;
    if (rx_rd)
      d.unread = 1'b0;
    if (status_wr & ~status_wdata[csst_pkg::ST_OVE_BIT])
      d.ovf = 1'b0;
    if (tx_push)
      d.comm = 1'b1;

    unique case (q.st)
      csst_pkg::CSST_IDLE:
      begin
        d.sck    = idle_lvl;
        d.div    = '0;
        d.bitcnt = '0;
        if (power & txe & fifo_valid)
        begin
          fifo_pop = 1'b1;
          d.sh     = fifo_data;
          d.dout   = out_bit(fifo_data, lsb_first, nbits);
          d.comm   = 1'b1;
          d.st     = csst_pkg::CSST_RUN;
        end
        else if (power & rxe & ~txe & rx_rd & sce)
        begin
          d.sh   = '0;
          d.comm = 1'b1;
          d.st   = csst_pkg::CSST_RUN;
        end
      end
      csst_pkg::CSST_RUN:
      begin
        if (master)
        begin
          d.div = tick ? '0 : q.div + 1'b1;
          if (tick)
            d.sck = ~q.sck;
        end
        if (lead & dap & (q.bitcnt != '0))
          d.dout = out_bit(q.sh, lsb_first, nbits);
        if (trail)
        begin
          d.sh     = sh_next;
          d.bitcnt = q.bitcnt + 5'h01;
          if (last_bit)
          begin
            d.st     = csst_pkg::CSST_IDLE;
            d.comm   = 1'b0;
            d.irq    = 1'b1;
            d.rx     = sh_next & mask;
            d.unread = 1'b1;
            // a read in this same cycle still counts as taken
            if (q.unread & ~rx_rd)
              d.ovf = 1'b1;
          end
          else if (~dap)
            d.dout = out_bit(sh_next, lsb_first, nbits);
        end
      end
      default:
      begin
        d.st = csst_pkg::CSST_IDLE;
      end
    endcase

    // power off aborts and wipes status
    if (~d.mc[csst_pkg::MC_POWER_BIT])
    begin
      d.st     = csst_pkg::CSST_IDLE;
      d.comm   = 1'b0;
      d.ovf    = 1'b0;
      d.unread = 1'b0;
      d.sck    = ~d.cp[csst_pkg::CP_CKP_BIT];
    end
    d.sck_oe = d.mc[csst_pkg::MC_POWER_BIT] &
               (d.cp[csst_pkg::CP_CKS_LSB +: csst_pkg::CP_CKS_W] != csst_pkg::CKS_SLAVE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk)
  begin
    if (srst)
      q <= CHAN_RESET;
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign tx_ready                = fifo_in_ready;
  assign rx_data                 = q.rx;
  assign main_control_reg        = q.mc;
  assign clock_phase_control_reg = q.cp;
  assign length_control_reg      = q.len;
  assign channel_status_reg      = {q.comm, 6'h00, q.ovf};
  assign communicating_flag      = q.comm;
  assign overrun_flag            = q.ovf;
  assign reception_complete_irq  = q.irq;
  assign serial_clock_pin_o      = q.sck;
  assign serial_clock_pin_oe     = q.sck_oe;
  assign serial_data_out_pin     = q.dout;

endmodule

/* File: tb/csst_chk.sv */
`timescale 1ns/1ns
module csst_chk (
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       main_ctl_wr,
  input wire logic [7:0] main_ctl_wdata,
  input wire logic       status_wr,
  input wire logic [7:0] status_wdata,
  input wire logic       tx_wr,
  input wire logic       tx_ready,
  input wire logic       rx_rd,
  input wire logic [7:0] main_control_reg,
  input wire logic [7:0] clock_phase_control_reg,
  input wire logic [7:0] channel_status_reg,
  input wire logic       communicating_flag,
  input wire logic       overrun_flag,
  input wire logic       reception_complete_irq,
  input wire logic       serial_clock_pin_o,
  input wire logic       serial_clock_pin_oe,
  input wire logic       serial_data_out_pin
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  logic [7:0] mc;
  logic       cf;
  logic       irq;
  assign mc = main_control_reg;
  assign cf = communicating_flag;
  assign irq = reception_complete_irq;
  ////////////////////////////////////////////////////////////////////////////
  a_oe_mode: assert property (
    serial_clock_pin_oe == (mc[7] && clock_phase_control_reg[2:0] != csst_pkg::CKS_SLAVE))
    else $error("clock enable does not follow mode");
  a_tx_start: assert property (
    tx_wr && mc[7] && mc[6] && tx_ready && !cf && !main_ctl_wr |=> cf)
    else $error("transmit write did not set busy");
  a_rx_start: assert property (
    rx_rd && !cf && !irq && mc[7:5] == 3'h5 && mc[0] && !main_ctl_wr |=> cf)
    else $error("dummy read did not start reception");
  a_rx_hold: assert property (
    rx_rd && !cf && mc[7:5] == 3'h5 && !mc[0] && !main_ctl_wr |=> !cf)
    else $error("read with continue clear started a frame");
  a_irq_end: assert property (
    irq |-> !cf && $past(cf) ##1 !irq)
    else $error("completion pulse not tied to end of busy");
  a_frame_len: assert property (
    $rose(cf) && serial_clock_pin_oe && clock_phase_control_reg[2:0] == 3'h0
    |-> ##[16:36] (irq || !mc[7]))
    else $error("master frame length out of range");
  a_idle_high: assert property (
    serial_clock_pin_oe && !cf |-> serial_clock_pin_o == !clock_phase_control_reg[4])
    else $error("serial clock not at idle level");
  a_data_hold: assert property (
    serial_clock_pin_oe && !serial_clock_pin_o && !clock_phase_control_reg[3]
    |-> $stable(serial_data_out_pin))
    else $error("data out moved on leading edge");
  a_status_map: assert property (
    channel_status_reg == {cf, 6'h00, overrun_flag})
    else $error("status byte mismatch");
  a_power_off: assert property (
    main_ctl_wr && !main_ctl_wdata[7] |=> !cf && channel_status_reg == 8'h00)
    else $error("power off left status set");
  a_ovf_clear: assert property (
    status_wr && !status_wdata[0] ##1 !irq |-> !overrun_flag)
    else $error("overrun not cleared");
  a_ovf_keep: assert property (
    status_wr && status_wdata[0] && overrun_flag && !main_ctl_wr |=> overrun_flag)
    else $error("writing one changed overrun");
  c_master: cover property (irq && serial_clock_pin_oe);
  c_slave: cover property (irq && !serial_clock_pin_oe);
  c_ovf: cover property ($rose(overrun_flag));
  c_full: cover property (!tx_ready && mc[7]);
endmodule

/* File: tb/csst_peer.sv */
`timescale 1ns/1ns
module csst_peer (
  input  wire logic        mclk,
  input  wire logic        sck,
  input  wire logic        dout,
  output logic             din,
  output logic             sck_drv,
  output logic      [15:0] rx_word
);
  logic [15:0] tx_word;
  logic [4:0]  nb;
  logic [4:0]  falls;
  logic        live;
  logic        tog;
  logic        bit_q;
  int          hold;
  // released line: toggles every cycle so a stale value never passes
  assign din = live ? bit_q : tog;
  initial
  begin
    sck_drv = 1'b1;
    live = 1'b0;
    tog = 1'b0;
    bit_q = 1'b0;
    rx_word = 16'h0000;
  end
  task automatic load(input logic [15:0] w, input logic [4:0] n);
    tx_word = w;
    nb = n;
    falls = 5'h00;
    hold = 0;
    live = 1'b1;
  endtask
  // clock stands high between frames
  task automatic clock_frame(input int n, input int h);
    repeat (n)
    begin
      repeat (h) @(negedge mclk);
      sck_drv = 1'b0;
      repeat (h) @(negedge mclk);
      sck_drv = 1'b1;
    end
    repeat (h) @(negedge mclk);
  endtask
  always @(negedge sck)
  begin
    rx_word <= {rx_word[14:0], dout};
    if (live && falls < nb)
    begin
      bit_q <= tx_word[nb - falls - 5'h01];
      falls <= falls + 5'h01;
    end
  end
  // hold the last bit a few cycles past the trailing edge
  always @(posedge mclk)
  begin
    tog <= ~tog;
    if (live && falls == nb && sck)
      hold <= hold + 1;
    if (hold == 4)
      live <= 1'b0;
  end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
bind csst_channel csst_chk chk (
  .mclk(mclk), .srst(srst), .main_ctl_wr(main_ctl_wr), .main_ctl_wdata(main_ctl_wdata),
  .status_wr(status_wr), .status_wdata(status_wdata), .tx_wr(tx_wr), .tx_ready(tx_ready),
  .rx_rd(rx_rd), .main_control_reg(main_control_reg),
  .clock_phase_control_reg(clock_phase_control_reg), .channel_status_reg(channel_status_reg),
  .communicating_flag(communicating_flag), .overrun_flag(overrun_flag),
  .reception_complete_irq(reception_complete_irq), .serial_clock_pin_o(serial_clock_pin_o),
  .serial_clock_pin_oe(serial_clock_pin_oe), .serial_data_out_pin(serial_data_out_pin)
);
module tb_top;
  logic        mclk, srst, tx_ready, comm, ovf, irq, sck_o, sck_oe, dout, din, sck_drv;
  logic [5:0]  stb;
  logic [15:0] wd, rx_data, p_rx;
  logic [7:0]  mc_q, cp_q, len_q, st_q;
  int          n_mismatch, n_tests, cyc;
  wire         sck = sck_oe ? sck_o : sck_drv;
  csst_channel uut (
    .mclk(mclk), .srst(srst), .main_ctl_wr(stb[0]), .main_ctl_wdata(wd[7:0]),
    .clk_phase_wr(stb[1]), .clk_phase_wdata(wd[7:0]), .len_ctl_wr(stb[2]),
    .len_ctl_wdata(wd[7:0]), .status_wr(stb[3]), .status_wdata(wd[7:0]), .tx_wr(stb[4]),
    .tx_wdata(wd), .tx_ready(tx_ready), .rx_rd(stb[5]), .rx_data(rx_data),
    .main_control_reg(mc_q), .clock_phase_control_reg(cp_q), .length_control_reg(len_q),
    .channel_status_reg(st_q), .communicating_flag(comm), .overrun_flag(ovf),
    .reception_complete_irq(irq), .serial_clock_pin_i(sck), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe(sck_oe), .serial_data_out_pin(dout), .serial_data_in_pin(din)
  );
  csst_peer peer (
    .mclk(mclk), .sck(sck), .dout(dout), .din(din), .sck_drv(sck_drv), .rx_word(p_rx)
  );
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // strobes: 0 main, 1 clock, 2 length, 3 status, 4 transmit, 5 receive read
  task automatic wr(input int r, input logic [15:0] d);
    @(negedge mclk);
    stb = 6'h01 << r;
    wd = d;
    @(negedge mclk);
    stb = 6'h00;
  endtask
  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 600)
    begin
      @(negedge mclk);
      k++;
    end
    chk("completion", 16'h0001, {15'h0, irq});
  endtask
  // power off first: clock and length only take while powered off or with both enables clear
  task automatic cfg(input logic [7:0] cp, input logic [7:0] ln, input logic [7:0] m);
    wr(0, 16'h0000);
    wr(1, {8'h00, cp});
    wr(2, {8'h00, ln});
    wr(0, {8'h00, m});
    chk("setup", {cp, ln}, {cp_q, len_q});
    chk("main", {8'h00, m}, {8'h00, mc_q});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_master_tx();
    cfg(8'h00, 8'h00, 8'hc1);
    chk("sck enable", 16'h0001, {15'h0, sck_oe});
    wr(4, 16'h001d);
    chk("busy", 16'h0001, {15'h0, comm});
    wait_irq();
    chk("sent", 16'h001d, {8'h00, p_rx[7:0]});
    chk("idle", 16'h0001, {14'h0, comm, sck_o});
    wr(4, 16'h006a);
    wait_irq();
    chk("sent", 16'h006a, {8'h00, p_rx[7:0]});
    chk("overrun", 16'h0001, {8'h00, st_q});
    wr(3, 16'h0001);
    chk("overrun kept", 16'h0001, {15'h0, ovf});
    wr(3, 16'h0000);
    chk("overrun clr", 16'h0000, {15'h0, ovf});
  endtask
  task automatic t_lengths();
    logic [7:0]  lv [5] = '{8'h00, 8'h03, 8'h07, 8'h08, 8'h0f};
    int          nv [5] = '{8, 11, 15, 16, 16};
    logic [15:0] m;
    for (int i = 0; i < 5; i++)
    begin
      m = 16'((32'h1 << nv[i]) - 1);
      cfg(8'h00, lv[i], 8'he1);
      peer.load(16'hc3a5, 5'(nv[i]));
      wr(4, 16'h5a3c);
      wait_irq();
      chk("peer got", 16'h5a3c & m, p_rx & m);
      chk("received", 16'hc3a5 & m, rx_data);
      wr(5, 16'h0000);
    end
  endtask
  task automatic t_master_rx();
    cfg(8'h00, 8'h00, 8'ha1);
    peer.load(16'h0096, 5'h08);
    wr(5, 16'h0000);
    chk("busy", 16'h0001, {15'h0, comm});
    wait_irq();
    chk("received", 16'h0096, rx_data);
    peer.load(16'h00c5, 5'h08);
    wr(5, 16'h0000);
    wait_irq();
    chk("received", 16'h00c5, rx_data);
    wr(0, 16'h00a0);
    wr(5, 16'h0000);
    chk("no restart", 16'h0000, {15'h0, comm});
    chk("read data", 16'h00c5, rx_data);
  endtask
  // lsb first at clock/4: both directions come back bit reversed
  task automatic t_lsb_div4();
    cfg(8'h01, 8'h00, 8'hf1);
    peer.load(16'h0003, 5'h08);
    wr(4, 16'h0001);
    wait_irq();
    chk("peer got", 16'h0080, {8'h00, p_rx[7:0]});
    chk("received", 16'h00c0, rx_data);
    wr(5, 16'h0000);
  endtask
  // far side stalls while the queue fills; tenth word must be refused
  task automatic t_slave_fifo();
    cfg(8'h07, 8'h00, 8'he1);
    chk("sck enable", 16'h0000, {15'h0, sck_oe});
    for (int i = 0; i < 10; i++)
      wr(4, 16'h0010 + 16'(i));
    chk("full", 16'h0001, {14'h0, tx_ready, comm});
    for (int i = 0; i < 9; i++)
    begin
      peer.load(16'h00a0 + 16'(i), 5'h08);
      fork
        peer.clock_frame(8, 8);
        wait_irq();
      join
      chk("peer got", 16'h0010 + 16'(i), {8'h00, p_rx[7:0]});
      chk("received", 16'h00a0 + 16'(i), rx_data);
      wr(5, 16'h0000);
    end
    chk("drained", 16'h0002, {14'h0, tx_ready, comm});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  initial
  begin
    n_mismatch = 0;
    n_tests = 0;
    cyc = 0;
    stb = 6'h00;
    wd = 16'h0000;
    srst = 1'b1;
    repeat (16) @(negedge mclk);
    srst = 1'b0;
    chk("regs", 16'h0000, {mc_q | st_q, cp_q | len_q});
    chk("pins", 16'h0005, {13'h0, sck_o, sck_oe, tx_ready});
    t_master_tx();
    t_lengths();
    t_master_rx();
    t_lsb_div4();
    t_slave_fifo();
    stop_test();
  end
endmodule
